// ---- core/quad_wiper_regs.vh ----
// Purpose: constants for the quad wiper serial register control
// Assumes: included by core/quad_wiper_spi_register_control.v
// Notes:   device-type code is arbitrary, not a real part code
`ifndef QUAD_WIPER_REGS_VH
`define QUAD_WIPER_REGS_VH
// ==========================================================
// identification byte
`define DEVICE_TYPE_CODE     4'ha
// ==========================================================
// command codes (upper nibble of second byte)
`define CMD_READ_WIPER       4'h9
`define CMD_WRITE_WIPER      4'ha
`define CMD_READ_STORED      4'hb
`define CMD_WRITE_STORED     4'hc
`define CMD_XFR_STORED_WIPER 4'hd
`define CMD_XFR_WIPER_STORED 4'he
`define CMD_GXFR_STORED_WIPER 4'h1
`define CMD_GXFR_WIPER_STORED 4'h8
`define CMD_READ_STATUS      4'h5
`define CMD_INC_DEC          4'h2
// ==========================================================
// timing
`define NV_WRITE_TIME_MS     10
`define SYS_CLK_HZ           10000000
`define NV_WRITE_CYCLES      ((`NV_WRITE_TIME_MS * `SYS_CLK_HZ) / 1000)
// ==========================================================
// reset values
`define STORED_RESET         8'h00
`endif

// ---- core/quad_wiper_spi_register_control.v ----
// Purpose: serial command decoder, wiper and stored-setting registers for four channels
// Assumes: serial pins asynchronous to sys_clk; serial clock well below sys_clk / 4
// Notes:   nonvolatile array modelled as flops; rst stands in for power-up
//
// Overview of operation
// - write-protect low blocks every stored-setting write.
// - serial input sampled on serial clock rising edge.
// - serial output is three-state, may share the input wire.
// - each wiper position decodes to one of 256 one-hot taps.
// - at most one tap switch enabled per channel.
// - write-wiper command loads wiper from serial data.
// - single or global transfer loads wiper from a stored setting.
// - increment/decrement command steps the wiper by one.
// - wiper volatile; power-up loads stored setting zero.
// - four 8-bit stored settings per channel, host readable and writable.
// - transfers both ways between stored settings and wiper.
// - stored-setting change completes within 10 ms.
// - nonvolatile save starts on select rising after complete write.
// - write-in-progress bit set during nonvolatile save.
// - read status command returns write-in-progress bit.
// - first byte after select falls is identification byte.
// - upper four identification bits compared with device-type code.
// - sequence continues only if low two bits match address straps.
// - read data shifted out on serial clock falling edge.
// - command byte: command nibble, stored select, channel select.
// - pause low/high during serial clock low keeps sequence state.
// - inc/dec moves wiper up for input high, down for low.
`timescale 1ns/1ns
`include "quad_wiper_regs.vh"
module quad_wiper_spi_register_control #(
  parameter NV_CYCLES = `NV_WRITE_CYCLES
) (
  input  wire          sys_clk,
  input  wire          rst,
  input  wire          clk_en,
  input  wire          chip_select_n,
  input  wire          serial_clock,
  input  wire          serial_in,
  input  wire          pause_n,
  input  wire          write_protect_n,
  input  wire [1:0]    address_strap,
  output reg           serial_out,
  output reg           serial_out_en,
  output reg           write_in_progress,
  output reg  [1023:0] tap_select
);
  // ==========================================================
  // synchronisers
  reg [1:0] cs_s, sck_s, si_s, hold_s, wp_s;
  reg [1:0] a0_s, a1_s;
  reg       sck_d;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cs_s   <= 2'h3;
      sck_s  <= 2'h0;
      si_s   <= 2'h0;
      hold_s <= 2'h3;
      wp_s   <= 2'h0;
      a0_s   <= 2'h0;
      a1_s   <= 2'h0;
      sck_d  <= 1'b0;
    end else if (clk_en) begin
      cs_s   <= {cs_s[0], chip_select_n};
      sck_s  <= {sck_s[0], serial_clock};
      si_s   <= {si_s[0], serial_in};
      hold_s <= {hold_s[0], pause_n};
      wp_s   <= {wp_s[0], write_protect_n};
      a0_s   <= {a0_s[0], address_strap[0]};
      a1_s   <= {a1_s[0], address_strap[1]};
      sck_d  <= sck_s[1];
    end
  end
  wire cs_n   = cs_s[1];
  wire si     = si_s[1];
  wire active = ~cs_n & hold_s[1];
  // pause only taken with the clock low, so edges simply stop arriving
  wire sck_rise = active & sck_s[1] & ~sck_d;
  wire sck_fall = active & ~sck_s[1] & sck_d;

  // ==========================================================
  // sequence state, one-hot
  localparam ST_ID   = 5'h01;
  localparam ST_CMD  = 5'h02;
  localparam ST_DATA = 5'h04;
  localparam ST_INC  = 5'h08;
  localparam ST_IDLE = 5'h10;

  reg [4:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] shift_in;
  reg [3:0] cmd;
  reg [1:0] reg_sel;
  reg [1:0] chan_sel;
  reg [7:0] shift_out;
  reg       reading;
  reg       nv_pending;
  reg       cs_d;
  reg [7:0] wiper [0:3];
  reg [7:0] stored [0:15];
  reg [7:0] pend_data [0:3];
  reg [3:0] pend_mask;
  reg [1:0] pend_reg;
  reg [31:0] nv_cnt;
  integer i;

  wire [7:0] byte_in  = {shift_in[6:0], si};
  wire       byte_end = sck_rise & (bit_cnt == 3'h7);
  wire       wp_ok    = wp_s[1];
  wire [3:0] c_cmd    = byte_in[7:4];
  wire [1:0] c_reg    = byte_in[3:2];
  wire [1:0] c_chan   = byte_in[1:0];
  wire       busy     = write_in_progress;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state             <= ST_IDLE;
      bit_cnt           <= 3'h0;
      shift_in          <= 8'h00;
      cmd               <= 4'h0;
      reg_sel           <= 2'h0;
      chan_sel          <= 2'h0;
      shift_out         <= 8'h00;
      reading           <= 1'b0;
      nv_pending        <= 1'b0;
      cs_d              <= 1'b1;
      pend_mask         <= 4'h0;
      pend_reg          <= 2'h0;
      nv_cnt            <= 32'h0;
      write_in_progress <= 1'b0;
      serial_out        <= 1'b0;
      serial_out_en     <= 1'b0;
      for (i = 0; i < 16; i = i + 1)
        stored[i] <= `STORED_RESET;
      // power-up recall of stored setting zero
      for (i = 0; i < 4; i = i + 1) begin
        wiper[i]     <= `STORED_RESET;
        pend_data[i] <= 8'h00;
      end
    end else if (clk_en) begin
      cs_d <= cs_n;
      // ======================================================
      // select edges
      if (cs_d & ~cs_n) begin
        state   <= ST_ID;
        bit_cnt <= 3'h0;
        reading <= 1'b0;
        nv_pending <= 1'b0;
      end
      if (~cs_d & cs_n) begin
        state         <= ST_IDLE;
        serial_out_en <= 1'b0;
        reading       <= 1'b0;
        // save starts only on select rise after a complete write
        if (nv_pending & wp_ok & ~busy) begin
          write_in_progress <= 1'b1;
          nv_cnt            <= 32'h0;
        end
        nv_pending <= 1'b0;
      end
      // ======================================================
      // nonvolatile timer; array updated at end of the save
      if (busy) begin
        if (nv_cnt >= NV_CYCLES - 1) begin
          write_in_progress <= 1'b0;
          for (i = 0; i < 4; i = i + 1)
            if (pend_mask[i])
              stored[{i[1:0], pend_reg}] <= pend_data[i];
        end else begin
          nv_cnt <= nv_cnt + 32'h1;
        end
      end
      // ======================================================
      // serial receive
      if (sck_rise) begin
        shift_in <= byte_in;
        bit_cnt  <= bit_cnt + 3'h1;
      end
      if (sck_rise) begin
        case (state)
          ST_ID: begin
            if (byte_end) begin
              // middle bits left unchecked, host keeps them zero
              if (byte_in[7:4] == `DEVICE_TYPE_CODE &&
                  byte_in[1:0] == {a1_s[1], a0_s[1]})
                state <= ST_CMD;
              else
                state <= ST_IDLE;
            end
          end
          ST_CMD: begin
            if (byte_end) begin
              cmd      <= c_cmd;
              reg_sel  <= c_reg;
              chan_sel <= c_chan;
              state    <= ST_IDLE;
              case (c_cmd)
                `CMD_READ_WIPER, `CMD_READ_STORED, `CMD_READ_STATUS: begin
                  reading <= 1'b1;
                  state   <= ST_DATA;
                  if (c_cmd == `CMD_READ_WIPER)
                    shift_out <= wiper[c_chan];
                  else if (c_cmd == `CMD_READ_STORED)
                    shift_out <= stored[{c_chan, c_reg}];
                  else
                    shift_out <= {7'h00, busy};
                end
                `CMD_WRITE_WIPER, `CMD_WRITE_STORED:
                  state <= ST_DATA;
                `CMD_INC_DEC:
                  state <= ST_INC;
                `CMD_XFR_STORED_WIPER:
                  wiper[c_chan] <= stored[{c_chan, c_reg}];
                `CMD_GXFR_STORED_WIPER:
                  for (i = 0; i < 4; i = i + 1)
                    wiper[i] <= stored[{i[1:0], c_reg}];
                `CMD_XFR_WIPER_STORED: if (~busy) begin
                  pend_mask <= 4'h1 << c_chan;
                  pend_reg  <= c_reg;
                  for (i = 0; i < 4; i = i + 1)
                    pend_data[i] <= wiper[i];
                  nv_pending <= 1'b1;
                end
                `CMD_GXFR_WIPER_STORED: if (~busy) begin
                  pend_mask <= 4'hf;
                  pend_reg  <= c_reg;
                  for (i = 0; i < 4; i = i + 1)
                    pend_data[i] <= wiper[i];
                  nv_pending <= 1'b1;
                end
                default: state <= ST_IDLE;
              endcase
            end
          end
          ST_DATA: begin
            if (byte_end) begin
              state <= ST_IDLE;
              if (cmd == `CMD_WRITE_WIPER)
                wiper[chan_sel] <= byte_in;
              else if (cmd == `CMD_WRITE_STORED && ~busy) begin
                pend_mask <= 4'h1 << chan_sel;
                pend_reg  <= reg_sel;
                pend_data[chan_sel] <= byte_in;
                nv_pending <= 1'b1;
              end
            end
          end
          ST_INC: begin
            // one step per pulse, held at the ends
            if (si && wiper[chan_sel] != 8'hff)
              wiper[chan_sel] <= wiper[chan_sel] + 8'h01;
            else if (!si && wiper[chan_sel] != 8'h00)
              wiper[chan_sel] <= wiper[chan_sel] - 8'h01;
          end
          ST_IDLE: begin
          end
          default: state <= ST_IDLE;
        endcase
      end
      // ======================================================
      // serial transmit on falling edges
      if (sck_fall && reading && state == ST_DATA) begin
        serial_out    <= shift_out[7];
        shift_out     <= {shift_out[6:0], 1'b0};
        serial_out_en <= 1'b1;
      end
      if (sck_rise && reading && state == ST_DATA && byte_end)
        reading <= 1'b0;
      if (~active)
        serial_out_en <= 1'b0;
    end
  end

  // ==========================================================
  // tap decode; registered so exactly one switch per channel is on after every edge
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : tap_dec
      always @(posedge sys_clk or posedge rst) begin
        if (rst)
          tap_select[g*256 +: 256] <= {{255{1'b0}}, 1'b1};
        else if (clk_en)
          tap_select[g*256 +: 256] <= {{255{1'b0}}, 1'b1} << wiper[g];
      end
    end
  endgenerate
endmodule

// ---- test/quad_wiper_assertions.sv ----
// Purpose: port checker for the quad wiper serial control
// Assumes: serial pins change on sys_clk falling edges
// Notes:   bound to the design top below
`timescale 1ns/1ns
module quad_wiper_assertions #(
  parameter NV_CYCLES = 100000
) (
  input wire          sys_clk,
  input wire          rst,
  input wire          chip_select_n,
  input wire          serial_clock,
  input wire          pause_n,
  input wire          write_protect_n,
  input wire          serial_out,
  input wire          serial_out_en,
  input wire          write_in_progress,
  input wire [1023:0] tap_select
);
  integer wip_cnt;
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      wip_cnt <= 0;
    else if (write_in_progress)
      wip_cnt <= wip_cnt + 1;
    else
      wip_cnt <= 0;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // idle and pause windows
  sequence s_deselected; chip_select_n [*5]; endsequence
  sequence s_paused; !pause_n [*5]; endsequence
  a_tap_one_hot: assert property (
    $onehot(tap_select[255:0]) && $onehot(tap_select[511:256]) &&
    $onehot(tap_select[767:512]) && $onehot(tap_select[1023:768])) else $error("tap select not one-hot");
  a_out_released: assert property (
    chip_select_n [*4] |-> !serial_out_en) else $error("serial out driven while deselected");
  a_out_enable_cause: assert property (
    $rose(serial_out_en) |-> !chip_select_n && pause_n) else $error("serial out enabled outside a frame");
  a_out_fall_edge: assert property (
    $changed(serial_out) |-> !serial_clock && $past(!serial_clock, 2)) else $error("serial out moved off falling edge");
  a_save_cause: assert property (
    $rose(write_in_progress) |-> chip_select_n && write_protect_n) else $error("save started without select rise");
  a_save_bound: assert property (
    wip_cnt <= NV_CYCLES + 2) else $error("nonvolatile save too long");
  a_idle_hold: assert property (
    s_deselected |-> $stable(tap_select)) else $error("wiper moved while deselected");
  a_pause_hold: assert property (
    s_paused |-> $stable(tap_select)) else $error("wiper moved during pause");
endmodule
bind quad_wiper_spi_register_control quad_wiper_assertions #(.NV_CYCLES(NV_CYCLES)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
  .pause_n(pause_n), .write_protect_n(write_protect_n), .serial_out(serial_out),
  .serial_out_en(serial_out_en), .write_in_progress(write_in_progress), .tap_select(tap_select));

// ---- test/quad_wiper_spi_register_control_tb.sv ----
// Purpose: self-checking bench for the quad wiper serial control
// Assumes: straps 2'b10, short save time
// Notes:   expectations built from the command layout
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin mismatches = mismatches + 1; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module quad_wiper_spi_register_control_tb;
  localparam NV = 400;
  localparam [7:0] ID = 8'ha2;
  reg           sys_clk, rst, write_protect_n, clk_en;
  reg  [1:0]    address_strap;
  wire          chip_select_n, serial_clock, serial_in, pause_n, serial_out, serial_out_en, write_in_progress;
  wire [1023:0] tap_select;
  // released line shows the inverse, so a bit taken while undriven cannot pass
  wire          so_line = serial_out_en ? serial_out : ~serial_out;
  integer       mismatches, n_checks, i;
  quad_wiper_spi_register_control #(.NV_CYCLES(NV)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_in(serial_in), .pause_n(pause_n),
    .write_protect_n(write_protect_n), .address_strap(address_strap), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .write_in_progress(write_in_progress), .tap_select(tap_select));
  spi_host_model host_u (
    .sys_clk(sys_clk), .serial_out(so_line), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_in(serial_in), .pause_n(pause_n), .rx());
  task tap(input [1:0] ch, input [7:0] v);
    `CHK(tap_select[ch*256 +: 256], 256'h1 << v)
  endtask
  task rd(input [7:0] cmd, input [7:0] v);
    begin
      host_u.frame(ID, cmd, 8'h00, 3);
      `CHK(host_u.rx, v)
      `CHK(serial_out_en, 1'b0)
    end
  endtask
  task nv_wait;
    begin
      i = 0;
      while (write_in_progress !== 1'b0 && i < NV + 50) begin @(negedge sys_clk); i = i + 1; end
      `CHK(write_in_progress, 1'b0)
    end
  endtask
  task t_wiper;
    begin
      for (i = 0; i < 4; i = i + 1) tap(i[1:0], 8'h00);
      for (i = 0; i < 4; i = i + 1) host_u.frame(ID, {6'h28, i[1:0]}, 8'h11 * i[7:0] + 8'h11, 3);
      for (i = 0; i < 4; i = i + 1) tap(i[1:0], 8'h11 * i[7:0] + 8'h11);
      host_u.frame(8'ha1, 8'ha0, 8'h99, 3);
      host_u.frame(8'h52, 8'ha0, 8'h99, 3);
      tap(0, 8'h11);
      rd(8'h92, 8'h33);
    end
  endtask
  task t_store;
    begin
      host_u.frame(ID, 8'hc9, 8'h5c, 3);
      `CHK(write_in_progress, 1'b1)
      rd(8'h50, 8'h01);
      nv_wait;
      rd(8'hb9, 8'h5c);
      host_u.frame(ID, 8'hd9, 8'h00, 2);
      tap(1, 8'h5c);
      write_protect_n = 1'b0;
      host_u.frame(ID, 8'hc9, 8'ha5, 3);
      `CHK(write_in_progress, 1'b0)
      write_protect_n = 1'b1;
      rd(8'hb9, 8'h5c);
    end
  endtask
  task t_xfr;
    begin
      host_u.frame(ID, 8'hec, 8'h00, 2);
      nv_wait;
      host_u.frame(ID, 8'h84, 8'h00, 2);
      nv_wait;
      host_u.frame(ID, 8'ha0, 8'h77, 3);
      host_u.frame(ID, 8'h14, 8'h00, 2);
      tap(0, 8'h11);
      tap(1, 8'h5c);
      host_u.frame(ID, 8'h1c, 8'h00, 2);
      tap(1, 8'h00);
    end
  endtask
  task t_incdec;
    begin
      host_u.frame(ID, 8'ha3, 8'hfb, 3);
      host_u.chip_select_n = 1'b0;
      host_u.xfer(ID); host_u.xfer(8'h23); host_u.xfer(8'hff); host_u.half;
      tap(3, 8'hff);
      host_u.xfer(8'h00); host_u.half;
      tap(3, 8'hf7);
      host_u.pause_n = 1'b0;
      host_u.xfer(8'h00);
      host_u.pause_n = 1'b1;
      host_u.xfer(8'hf0); host_u.half;
      tap(3, 8'hf7);
      host_u.chip_select_n = 1'b1;
      host_u.half;
      host_u.frame(ID, 8'ha3, 8'h05, 3);
      host_u.frame(ID, 8'h23, 8'h00, 3);
      tap(3, 8'h00);
    end
  endtask
  // a frozen block must ignore a whole frame, then resume
  task t_freeze;
    begin
      clk_en = 1'b0;
      host_u.frame(ID, 8'ha0, 8'h3c, 3);
      clk_en = 1'b1;
      host_u.half;
      tap(0, 8'h11);
      host_u.frame(ID, 8'ha0, 8'h3c, 3);
      tap(0, 8'h3c);
    end
  endtask
  task wrap_up;
    begin
      if (mismatches == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // run needs about 5800 cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    mismatches = mismatches + 1;
    wrap_up;
  end
  initial begin
    rst = 1'b1; write_protect_n = 1'b1; address_strap = 2'b10; mismatches = 0; n_checks = 0;
    clk_en = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_wiper; t_store; t_xfr; t_freeze; t_incdec;
    wrap_up;
  end
endmodule

// ---- test/spi_host_model.sv ----
// Purpose: serial host driving select, clock, data and pause
// Assumes: half serial period of four sys_clk, 800 ns period
// Notes:   clock idles low and stands still outside frames
`timescale 1ns/1ns
module spi_host_model (
  input  wire       sys_clk,
  input  wire       serial_out,
  output reg        chip_select_n,
  output reg        serial_clock,
  output reg        serial_in,
  output reg        pause_n,
  output reg  [7:0] rx
);
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
    pause_n = 1'b1;
    rx = 8'h00;
  end
  task half;
    repeat (4) @(negedge sys_clk);
  endtask
  // msb first, data set while clock low, read bit taken just before the fall
  task xfer(input [7:0] tx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      serial_in = tx[i];
      half;
      serial_clock = 1'b1;
      half;
      rx = {rx[6:0], serial_out};
      serial_clock = 1'b0;
    end
  endtask
  // select held low for the whole frame
  task frame(input [7:0] a, input [7:0] b, input [7:0] c, input integer n);
    begin
      chip_select_n = 1'b0;
      half;
      xfer(a);
      xfer(b);
      if (n > 2)
        xfer(c);
      half;
      chip_select_n = 1'b1;
      // released line flips so a stale level is never mistaken for data
      serial_in = ~serial_in;
      half;
    end
  endtask
endmodule
